/* hdl/ats_defs.svh */
// Purpose: Offsets, field positions, reset values and counts of the slot sequencer
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes:
// Notes on behaviour
// - Each slot drives the five word-select pins from the record's pattern bits.
// - Pins 0 and 4 set as input triggers ignore their pattern bits.
// - Input select 00 takes line 0 for port two, line 4 for port one.
// - Word-buffer load bit puts received byte in next free Dword buffer byte.
// - Feedback load bit puts received byte in next free feedback buffer byte.
// - Store bit writes the assembled Dword buffer into the input queue.
// - Fetch bit moves the next output queue word into the output buffer.
// - Byte select 000 to 011 sends output buffer byte 0 to 3.
// - Byte select 100 to 111 sends feedback buffer byte 0 to 3.
// - Output select 00 drives line 0 for port one, line 4 for port two.
// - Both ports on one output line: port one drives, port two is suppressed.
// - Lines nobody drives in a slot stay high impedance.
// - Drive-low bit pulls previous slot's output line low seven bit clocks, then releases.
// - End-of-superframe record makes the next slot use the first record.
// - Each list holds sixteen 32-bit records; port two's at 0x1c0 to 0x1fc.
// - Chained mode joins both lists under one pointer of up to 32 slots.
`ifndef ATS_DEFS_SVH
`define ATS_DEFS_SVH
`define ATS_CTRL_OFS 9'h000
`define ATS_STAT_OFS 9'h004
`define ATS_OUT1_OFS 9'h008
`define ATS_OUT2_OFS 9'h00c
`define ATS_IN1_OFS 9'h010
`define ATS_IN2_OFS 9'h014
`define ATS_LIST1_OFS 9'h180
`define ATS_LIST2_OFS 9'h1c0
`define ATS_CTRL_RST 5'h00
`define ATS_CTRL_EN1 0
`define ATS_CTRL_EN2 1
`define ATS_CTRL_CHAIN 2
`define ATS_CTRL_TRIG0 3
`define ATS_CTRL_TRIG4 4
`define ATS_REC_WS_MSB 31
`define ATS_REC_DIS_LSB 24
`define ATS_REC_SDW 23
`define ATS_REC_SIB 22
`define ATS_REC_SF 21
`define ATS_REC_LF 20
`define ATS_REC_BSEL_LSB 17
`define ATS_REC_DOD_LSB 15
`define ATS_REC_LOW 14
`define ATS_REC_EOS 0
`define ATS_PORT_STRIDE 13
`define ATS_LOW_BITS 3'h7
`define ATS_SLOT_LAST 3'h7
`endif

/* hdl/ats_pkg.sv */
// Purpose: Shared types of the slot sequencer
// Assumes: Nothing
// Notes: Constants live in ats_defs.svh
package ats_pkg;
    typedef logic [31:0] ats_word_t;
    typedef logic [4:0] ats_idx_t;
    typedef logic [2:0] ats_line_t;
endpackage

/* hdl/ats_mem_if.sv */
// Purpose: Carrier between sequencer and record memory
// Assumes: Write and bus read on clk_i, link reads on link clock
// Notes: None
`timescale 1ns/1ns
`default_nettype none
interface ats_mem_if;
    logic wr_en;
    logic [3:0] wr_sel;
    ats_pkg::ats_idx_t wr_idx;
    ats_pkg::ats_word_t wr_data;
    ats_pkg::ats_idx_t bus_idx;
    ats_pkg::ats_word_t bus_data;
    ats_pkg::ats_idx_t idx_a;
    ats_pkg::ats_idx_t idx_b;
    ats_pkg::ats_word_t data_a;
    ats_pkg::ats_word_t data_b;
    modport mem(input wr_en, wr_sel, wr_idx, wr_data, bus_idx, idx_a, idx_b,
        output bus_data, data_a, data_b);
    modport user(output wr_en, wr_sel, wr_idx, wr_data, bus_idx, idx_a, idx_b,
        input bus_data, data_a, data_b);
endinterface
`default_nettype wire

/* hdl/ats_list_mem.sv */
// Purpose: Record store for both slot lists
// Assumes: Records change only while their list is idle
// Notes: All read data come from registers
`timescale 1ns/1ns
`default_nettype none
module ats_list_mem #(
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rd_clk_i,
    ats_mem_if.mem mp
);
    // ****************
    // Byte lanes, one store each
    // ****************
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            logic [7:0] lane_ff [DEPTH];
            always_ff @(posedge clk_i) begin
                if (mp.wr_en && mp.wr_sel[b]) begin
                    lane_ff[mp.wr_idx] <= mp.wr_data[b*8 +: 8];
                end
            end
            always_ff @(posedge clk_i) begin
                mp.bus_data[b*8 +: 8] <= lane_ff[mp.bus_idx];
            end
            always_ff @(posedge rd_clk_i) begin
                mp.data_a[b*8 +: 8] <= lane_ff[mp.idx_a];
                mp.data_b[b*8 +: 8] <= lane_ff[mp.idx_b];
            end
        end
    endgenerate
endmodule // ats_list_mem
`default_nettype wire

/* hdl/ats_seq_top.sv */
// Purpose: Record-driven time slot sequencer for two serial audio ports
// Assumes: Bit clock on link_clk_i runs freely; one byte per slot of eight bits
// Notes: Port index 0 is port one, index 1 is port two
//
// Our own choices: the Wishbone register port and the register offsets.
`include "ats_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module ats_seq_top #(
    parameter int LIST_DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic link_clk_i,
    input wire logic [4:0] sd_i,
    output logic [4:0] sd_o,
    output logic [4:0] sd_oe_o,
    output logic [4:0] ws_o,
    output logic [4:0] ws_oe_o
);
    ats_mem_if mif ();

    ats_list_mem #(
        .DEPTH(2 * LIST_DEPTH)
    ) u_mem (
        .clk_i(clk_i),
        .rd_clk_i(link_clk_i),
        .mp(mif.mem)
    );

    // ****************
    // Bus slave
    // ****************
    logic ack_ff;
    logic list_hit_ff;
    logic [31:0] rd_ff;
    logic [4:0] ctrl_ff;
    logic [31:0] out_word_ff [2];
    logic [1:0] out_full_ff;
    logic [31:0] in_word_ff [2];
    logic [1:0] in_valid_ff;
    logic [31:0] lk_in_ff [2];
    logic [1:0] fetch_done;
    logic [1:0] store_seen;

    wire bus_req = wb_cyc_i & wb_stb_i;
    wire wr_go = bus_req & wb_we_i & ack_ff;
    wire rd_go = bus_req & ~wb_we_i & ack_ff;
    wire list_hit = wb_adr_i >= `ATS_LIST1_OFS;
    wire hit_ctrl = wb_adr_i == `ATS_CTRL_OFS;
    wire hit_stat = wb_adr_i == `ATS_STAT_OFS;
    wire [1:0] hit_out = {wb_adr_i == `ATS_OUT2_OFS, wb_adr_i == `ATS_OUT1_OFS};
    wire [1:0] hit_in = {wb_adr_i == `ATS_IN2_OFS, wb_adr_i == `ATS_IN1_OFS};
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] rd_mux = hit_ctrl ? {27'h0000000, ctrl_ff} :
        hit_stat ? {28'h0000000, in_valid_ff, out_full_ff} :
        hit_in[0] ? in_word_ff[0] : hit_in[1] ? in_word_ff[1] : 32'h00000000;

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = list_hit_ff ? mif.bus_data : rd_ff;
    assign mif.wr_en = wr_go & list_hit;
    assign mif.wr_sel = wb_sel_i;
    assign mif.wr_idx = wb_adr_i[6:2];
    assign mif.wr_data = wb_dat_i;
    assign mif.bus_idx = wb_adr_i[6:2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            list_hit_ff <= 1'b0;
            rd_ff <= 32'h00000000;
            ctrl_ff <= `ATS_CTRL_RST;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
            list_hit_ff <= list_hit;
            rd_ff <= rd_mux;
            if (wr_go && hit_ctrl && wb_sel_i[0]) begin
                ctrl_ff <= wb_dat_i[4:0];
            end
        end
    end

    // ****************
    // Queue mailboxes, bus side
    // ****************
    genvar q;
    generate
        for (q = 0; q < 2; q++) begin : g_box
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    out_word_ff[q] <= 32'h00000000;
                    out_full_ff[q] <= 1'b0;
                    in_word_ff[q] <= 32'h00000000;
                    in_valid_ff[q] <= 1'b0;
                end else begin
                    if (wr_go && hit_out[q]) begin
                        out_word_ff[q] <= (out_word_ff[q] & ~wmask) | (wb_dat_i & wmask);
                    end
                    out_full_ff[q] <= (wr_go & hit_out[q]) | (out_full_ff[q] & ~fetch_done[q]);
                    if (store_seen[q]) begin
                        in_word_ff[q] <= lk_in_ff[q];
                    end
                    in_valid_ff[q] <= store_seen[q] | (in_valid_ff[q] & ~(rd_go & hit_in[q]));
                end
            end
        end
    endgenerate

    // ****************
    // Crossings
    // ****************
    logic lrst_meta_ff;
    logic lrst_ff;
    logic [4:0] cfg_meta_ff;
    logic [4:0] cfg_ff;
    logic [1:0] full_meta_ff;
    logic [1:0] full_ff;
    logic [4:0] sd_meta_ff;
    logic [4:0] sd_ff;
    logic [1:0] fetch_tgl_ff;
    logic [1:0] store_tgl_ff;
    logic [1:0] ftg_meta_ff;
    logic [1:0] ftg_ff;
    logic [1:0] ftg_old_ff;
    logic [1:0] stg_meta_ff;
    logic [1:0] stg_ff;
    logic [1:0] stg_old_ff;

    always_ff @(posedge link_clk_i) begin
        lrst_meta_ff <= rst_i;
        lrst_ff <= lrst_meta_ff;
        cfg_meta_ff <= ctrl_ff;
        cfg_ff <= cfg_meta_ff;
        full_meta_ff <= out_full_ff;
        full_ff <= full_meta_ff;
        sd_meta_ff <= sd_i;
        sd_ff <= sd_meta_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ftg_meta_ff <= 2'h0;
            ftg_ff <= 2'h0;
            ftg_old_ff <= 2'h0;
            stg_meta_ff <= 2'h0;
            stg_ff <= 2'h0;
            stg_old_ff <= 2'h0;
        end else begin
            ftg_meta_ff <= fetch_tgl_ff;
            ftg_ff <= ftg_meta_ff;
            ftg_old_ff <= ftg_ff;
            stg_meta_ff <= store_tgl_ff;
            stg_ff <= stg_meta_ff;
            stg_old_ff <= stg_ff;
        end
    end
    assign fetch_done = ftg_ff ^ ftg_old_ff;
    assign store_seen = stg_ff ^ stg_old_ff;

    // ****************
    // Slot timing and pointers
    // ****************
    logic [2:0] bit_cnt_ff;
    logic [4:0] ptr1_ff;
    logic [3:0] ptr2_ff;

    wire en1 = cfg_ff[`ATS_CTRL_EN1];
    wire en2 = cfg_ff[`ATS_CTRL_EN2];
    wire chain = cfg_ff[`ATS_CTRL_CHAIN];
    wire slot_end = bit_cnt_ff == `ATS_SLOT_LAST;
    wire [1:0] port_en = {en2, en1};
    wire ptr1_run = en1 | (chain & en2);
    wire [4:0] ptr1_inc = chain ? ptr1_ff + 5'h01 : {1'b0, ptr1_ff[3:0] + 4'h1};
    wire [31:0] rec_src [2];
    assign rec_src[0] = mif.data_a;
    assign rec_src[1] = chain ? mif.data_a : mif.data_b;
    assign mif.idx_a = chain ? ptr1_ff : {1'b0, ptr1_ff[3:0]};
    assign mif.idx_b = {1'b1, ptr2_ff};

    always_ff @(posedge link_clk_i) begin
        if (lrst_ff) begin
            bit_cnt_ff <= 3'h0;
            ptr1_ff <= 5'h00;
            ptr2_ff <= 4'h0;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (!ptr1_run) begin
                ptr1_ff <= 5'h00;
            end else if (slot_end) begin
                ptr1_ff <= mif.data_a[`ATS_REC_EOS] ? 5'h00 : ptr1_inc;
            end
            if (!en2 || chain) begin
                ptr2_ff <= 4'h0;
            end else if (slot_end) begin
                ptr2_ff <= mif.data_b[`ATS_REC_EOS] ? 4'h0 : ptr2_ff + 4'h1;
            end
        end
    end

    // ****************
    // Per-port slot engine
    // ****************
    logic [31:0] cur_rec_ff [2];
    ats_pkg::ats_line_t out_line [2];
    logic [1:0] tx_bit;
    logic [2:0] low_cnt_ff [2];
    ats_pkg::ats_line_t low_line_ff [2];

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            localparam int SH = p * `ATS_PORT_STRIDE;
            logic [31:0] wbuf_ff;
            logic [1:0] wpos_ff;
            logic [31:0] fbuf_ff;
            logic [1:0] fpos_ff;
            logic [31:0] out_dw_ff;
            logic [7:0] tx_ff;
            logic [6:0] rx_ff;
            logic [31:0] nxt_wbuf;
            wire [31:0] rc = cur_rec_ff[p] << SH;
            wire [31:0] rn = rec_src[p] << SH;
            wire [1:0] dis = rc[`ATS_REC_DIS_LSB +: 2];
            wire [2:0] in_line = dis != 2'h0 ? {1'b0, dis} : (p == 0 ? 3'h4 : 3'h0);
            wire [7:0] rx_byte = {rx_ff, sd_ff[in_line]};
            wire [2:0] bsel = rn[`ATS_REC_BSEL_LSB +: 3];
            wire [31:0] tx_src = bsel[2] ? fbuf_ff : out_dw_ff;
            wire [1:0] dod = rc[`ATS_REC_DOD_LSB +: 2];
            wire do_fetch = rc[`ATS_REC_LF] & full_ff[p];
            assign out_line[p] = dod != 2'h0 ? {1'b0, dod} : (p == 0 ? 3'h0 : 3'h4);
            assign tx_bit[p] = tx_ff[7];

            always_comb begin
                nxt_wbuf = wbuf_ff;
                if (rc[`ATS_REC_SDW]) begin
                    nxt_wbuf[wpos_ff*8 +: 8] = rx_byte;
                end
            end

            always_ff @(posedge link_clk_i) begin
                if (lrst_ff || !port_en[p]) begin
                    cur_rec_ff[p] <= 32'h00000000;
                    wbuf_ff <= 32'h00000000;
                    wpos_ff <= 2'h0;
                    fbuf_ff <= 32'h00000000;
                    fpos_ff <= 2'h0;
                    tx_ff <= 8'h00;
                    rx_ff <= 7'h00;
                    low_cnt_ff[p] <= 3'h0;
                    low_line_ff[p] <= 3'h0;
                end else begin
                    rx_ff <= rx_byte[6:0];
                    tx_ff <= {tx_ff[6:0], 1'b0};
                    if (low_cnt_ff[p] != 3'h0) begin
                        low_cnt_ff[p] <= low_cnt_ff[p] - 3'h1;
                    end
                    if (slot_end) begin
                        cur_rec_ff[p] <= rec_src[p];
                        tx_ff <= tx_src[bsel[1:0]*8 +: 8];
                        wbuf_ff <= nxt_wbuf;
                        wpos_ff <= rc[`ATS_REC_SF] ? 2'h0 : wpos_ff + {1'b0, rc[`ATS_REC_SDW]};
                        if (rc[`ATS_REC_SIB]) begin
                            fbuf_ff[fpos_ff*8 +: 8] <= rx_byte;
                            fpos_ff <= fpos_ff + 2'h1;
                        end
                        if (rn[`ATS_REC_LOW]) begin
                            low_cnt_ff[p] <= `ATS_LOW_BITS;
                            low_line_ff[p] <= out_line[p];
                        end
                    end
                end
            end

            always_ff @(posedge link_clk_i) begin
                if (lrst_ff) begin
                    out_dw_ff <= 32'h00000000;
                    lk_in_ff[p] <= 32'h00000000;
                    store_tgl_ff[p] <= 1'b0;
                    fetch_tgl_ff[p] <= 1'b0;
                end else if (slot_end && port_en[p]) begin
                    if (rc[`ATS_REC_SF]) begin
                        lk_in_ff[p] <= nxt_wbuf;
                        store_tgl_ff[p] <= ~store_tgl_ff[p];
                    end
                    if (do_fetch) begin
                        out_dw_ff <= out_word_ff[p];
                        fetch_tgl_ff[p] <= ~fetch_tgl_ff[p];
                    end
                end
            end
        end
    endgenerate

    // ****************
    // Pin drivers
    // ****************
    wire [31:0] ws_rec = en1 ? cur_rec_ff[0] : cur_rec_ff[1];
    wire [4:0] ws_trig = {cfg_ff[`ATS_CTRL_TRIG4], 3'h0, cfg_ff[`ATS_CTRL_TRIG0]};
    wire [4:0] ws_en = {5{en1 | en2}} & ~ws_trig;
    wire [4:0] ws_pat = {ws_rec[27], ws_rec[28], ws_rec[29], ws_rec[30], ws_rec[31]};
    logic [4:0] nxt_sd_o;
    logic [4:0] nxt_sd_oe;

    genvar l;
    generate
        for (l = 0; l < 5; l++) begin : g_line
            wire act1 = en1 && out_line[0] == l;
            wire act2 = en2 && out_line[1] == l && !act1;
            wire low1 = low_cnt_ff[0] != 3'h0 && low_line_ff[0] == l;
            wire low2 = low_cnt_ff[1] != 3'h0 && low_line_ff[1] == l;
            assign nxt_sd_oe[l] = act1 | act2 | low1 | low2;
            assign nxt_sd_o[l] = act1 ? tx_bit[0] : (act2 ? tx_bit[1] : 1'b0);
        end
    endgenerate

    always_ff @(posedge link_clk_i) begin
        if (lrst_ff) begin
            sd_o <= 5'h00;
            sd_oe_o <= 5'h00;
            ws_o <= 5'h00;
            ws_oe_o <= 5'h00;
        end else begin
            sd_o <= nxt_sd_o;
            sd_oe_o <= nxt_sd_oe;
            ws_o <= ws_pat & ws_en;
            ws_oe_o <= ws_en;
        end
    end

    // ****************
    // Assertions
    // ****************
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_ff |=> !ack_ff) else $error("ack longer than one cycle");
    AST_WS_PAT: assert property (@(posedge link_clk_i) disable iff (lrst_ff)
        (en1 && slot_end) ##1 en1 |=> ws_o[3:1] == {$past(mif.data_a[28], 2), $past(mif.data_a[29], 2),
        $past(mif.data_a[30], 2)}) else $error("word-select pattern mismatch");
    AST_WS_TRIG: assert property (@(posedge link_clk_i) disable iff (lrst_ff)
        cfg_ff[`ATS_CTRL_TRIG0] |=> !ws_oe_o[0] && !ws_o[0]) else $error("trigger pin driven");
    AST_EOS: assert property (@(posedge link_clk_i) disable iff (lrst_ff)
        (ptr1_run && slot_end && mif.data_a[0]) |=> ptr1_ff == 5'h00) else $error("pointer not reset");
    AST_STEP: assert property (@(posedge link_clk_i) disable iff (lrst_ff)
        (en2 && !chain && slot_end && !mif.data_b[0]) |=> ptr2_ff == $past(ptr2_ff) + 4'h1)
        else $error("pointer did not step");
    AST_HOLD: assert property (@(posedge link_clk_i) disable iff (lrst_ff)
        (ptr1_run && !slot_end) |=> ptr1_ff == $past(ptr1_ff)) else $error("pointer moved mid-slot");
    AST_PRIO: assert property (@(posedge link_clk_i) disable iff (lrst_ff)
        (en1 && en2 && out_line[0] == out_line[1] && out_line[0] == 3'h1)
        |=> sd_oe_o[1] && sd_o[1] == $past(tx_bit[0])) else $error("port one lost line");
    AST_HIZ: assert property (@(posedge link_clk_i) disable iff (lrst_ff)
        (!en1 && !en2 && low_cnt_ff[0] == 3'h0 && low_cnt_ff[1] == 3'h0) |=> sd_oe_o == 5'h00)
        else $error("idle line driven");
    AST_LOW: assert property (@(posedge link_clk_i) disable iff (lrst_ff)
        (en1 && slot_end && mif.data_a[`ATS_REC_LOW]) |=> low_cnt_ff[0] == 3'h7 ##6 low_cnt_ff[0] == 3'h1
        ##1 low_cnt_ff[0] == 3'h0) else $error("low drive length wrong");
    AST_STORE: assert property (@(posedge link_clk_i) disable iff (lrst_ff)
        (en1 && slot_end && cur_rec_ff[0][`ATS_REC_SF]) |=> store_tgl_ff[0] != $past(store_tgl_ff[0]))
        else $error("store not signalled");
    COV_EOS: cover property (@(posedge link_clk_i) slot_end && ptr1_run && mif.data_a[0]);
    COV_PRIO: cover property (@(posedge link_clk_i) en1 && en2 && out_line[0] == out_line[1]);
    COV_LOW: cover property (@(posedge link_clk_i) low_cnt_ff[0] == 3'h7);
    COV_CHAIN: cover property (@(posedge link_clk_i) chain && ptr1_ff == 5'h10);
endmodule // ats_seq_top
`default_nettype wire

/* tb/ats_codec_model.sv */
// Purpose: Serial codec stand-in on the five data lines
// Assumes: Codec drives each line at a static level when the device does not
// Notes: Keeps the last output run seen on lines 0 and 1
`timescale 1ns/1ns
`default_nettype none
module ats_codec_model (
    input wire logic link_clk_i,
    input wire logic clr_i,
    input wire logic [4:0] lvl_i,
    input wire logic [4:0] sd_o_i,
    input wire logic [4:0] sd_oe_i,
    output logic [4:0] sd_line_o,
    output logic [31:0] cap0_o,
    output logic [31:0] cap1_o,
    output logic [4:0] oe_seen_o
);
    // ************************************************
    // Line resolution and output capture
    // ************************************************
    logic [31:0] sh0_ff;
    logic [31:0] sh1_ff;
    logic [1:0] run_ff;
    assign sd_line_o = (sd_oe_i & sd_o_i) | (~sd_oe_i & lvl_i);
    always @(negedge link_clk_i) begin
        if (sd_oe_i[0]) sh0_ff <= {sh0_ff[30:0], sd_o_i[0]};
        if (sd_oe_i[1]) sh1_ff <= {sh1_ff[30:0], sd_o_i[1]};
        if (!sd_oe_i[0] && run_ff[0]) cap0_o <= sh0_ff;
        if (!sd_oe_i[1] && run_ff[1]) cap1_o <= sh1_ff;
        run_ff <= sd_oe_i[1:0];
        oe_seen_o <= clr_i ? 5'h00 : (oe_seen_o | sd_oe_i);
    end
endmodule // ats_codec_model
`default_nettype wire

/* tb/test_audio_time_slot_list_sequencer.sv */
// Purpose: Self-checking bench of the slot sequencer
// Assumes: Port one alone with a four-record superframe, then port two alone
// Notes: Random records, levels and output word from a fixed seed
`include "ats_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module test_audio_time_slot_list_sequencer;
    // ************************************************
    // Clocks, design and codec
    // ************************************************
    logic clk_i = 1'b0;
    logic link_clk = 1'b1;
    logic rst_i = 1'b1;
    logic [8:0] adr = 9'h000;
    logic [31:0] dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic wb_ack_o;
    logic clr = 1'b1;
    logic [4:0] lvl = 5'h00;
    logic [4:0] sd_line, sd_o, sd_oe_o, ws_o, ws_oe_o, oe_seen;
    logic [31:0] cap0, cap1, q, w;
    logic [31:0] r [0:31];
    logic [4:0] p [0:3];
    int n_mismatch = 0;
    int n_tests = 0;
    always #5 clk_i = ~clk_i;
    always #3 link_clk = ~link_clk;
    ats_seq_top #(.LIST_DEPTH(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(wb_ack_o), .link_clk_i(link_clk), .sd_i(sd_line), .sd_o(sd_o), .sd_oe_o(sd_oe_o),
        .ws_o(ws_o), .ws_oe_o(ws_oe_o));
    ats_codec_model codec (.link_clk_i(link_clk), .clr_i(clr), .lvl_i(lvl), .sd_o_i(sd_o),
        .sd_oe_i(sd_oe_o), .sd_line_o(sd_line), .cap0_o(cap0), .cap1_o(cap1), .oe_seen_o(oe_seen));
    // ************************************************
    // Tasks and expectations
    // ************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    function automatic logic [31:0] rec(input logic [4:0] ws, input logic [1:0] dis, input logic sf,
        input logic lf, input logic [2:0] bsel, input logic [1:0] dod, input logic end_of_superframe_flag, input logic [31:0] x);
        return {ws[0], ws[1], ws[2], ws[3], ws[4], 1'b0, dis, 1'b1, 1'b0, sf, lf, bsel, dod, 1'b0, x[13:1], end_of_superframe_flag};
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        void'($urandom(32'h74891a99));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, `ATS_CTRL_OFS, 32'h0, q); chk(q, 32'h0);
        bus(1'b0, `ATS_STAT_OFS, 32'h0, q); chk(q, 32'h0);
        bus(1'b0, 9'h100, 32'h0, q); chk(q, 32'h0);
        for (int i = 0; i < 32; i++) begin
            r[i] = $urandom;
            bus(1'b1, `ATS_LIST1_OFS + 9'(4 * i), r[i], q);
        end
        for (int i = 0; i < 32; i++) begin
            bus(1'b0, `ATS_LIST1_OFS + 9'(4 * i), 32'h0, q); chk(q, r[i]);
        end
        for (int i = 0; i < 4; i++) p[i] = 5'($urandom);
        lvl <= 5'($urandom);
        w = $urandom;
        bus(1'b1, `ATS_OUT1_OFS, w, q);
        bus(1'b1, 9'h180, rec(p[0], 2'b00, 1'b0, 1'b1, 3'b000, 2'b01, 1'b0, r[0]), q);
        bus(1'b1, 9'h184, rec(p[1], 2'b10, 1'b0, 1'b0, 3'b001, 2'b00, 1'b0, r[1]), q);
        bus(1'b1, 9'h188, rec(p[2], 2'b11, 1'b0, 1'b0, 3'b010, 2'b00, 1'b0, r[2]), q);
        bus(1'b1, 9'h18c, rec(p[3], 2'b01, 1'b1, 1'b0, 3'b011, 2'b00, 1'b1, r[3]), q);
        clr <= 1'b0;
        bus(1'b1, `ATS_CTRL_OFS, 32'h1, q);
        repeat (100) @(negedge link_clk);
        repeat (64) begin
            @(negedge link_clk);
            chk({31'h0, ws_o === p[0] || ws_o === p[1] || ws_o === p[2] || ws_o === p[3]}, 32'h1);
        end
        chk(cap1, {cap1[31:8], w[7:0]});
        chk(cap0[23:0], {w[15:8], w[23:16], w[31:24]});
        chk({27'h0, oe_seen}, 32'h3);
        bus(1'b0, `ATS_STAT_OFS, 32'h0, q); chk(q & 32'h1, 32'h0);
        bus(1'b0, `ATS_IN1_OFS, 32'h0, q);
        chk(q, {{8{lvl[1]}}, {8{lvl[3]}}, {8{lvl[2]}}, {8{lvl[4]}}});
        bus(1'b1, `ATS_CTRL_OFS, 32'h19, q);
        bus(1'b0, `ATS_CTRL_OFS, 32'h0, q); chk(q, 32'h19);
        repeat (20) @(negedge link_clk);
        chk({27'h0, ws_oe_o}, 32'he);
        bus(1'b1, `ATS_CTRL_OFS, 32'h0, q);
        clr <= 1'b1;
        bus(1'b1, `ATS_OUT2_OFS, ~w, q);
        bus(1'b1, `ATS_LIST2_OFS, 32'h00000084, q);
        bus(1'b1, `ATS_LIST2_OFS + 9'h004, 32'h00000001, q);
        clr <= 1'b0;
        bus(1'b1, `ATS_CTRL_OFS, 32'h2, q);
        repeat (100) @(negedge link_clk);
        chk({24'h0, cap1[7:0]}, {24'h0, ~w[7:0]});
        chk({27'h0, oe_seen}, 32'h12);
        bus(1'b0, `ATS_STAT_OFS, 32'h0, q); chk(q & 32'h2, 32'h0);
        finish_test();
    end
endmodule // test_audio_time_slot_list_sequencer
`default_nettype wire
